// >>> pkg/lsb_pkg.sv
// package for the low-speed lane error and status bank
package lsb_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  LSB_IDX_LANE1_CNT    = 8'h12;
  localparam logic [7:0]  LSB_IDX_LANE2_CNT    = 8'h13;
  localparam logic [7:0]  LSB_IDX_LANE3_CNT    = 8'h14;
  localparam logic [7:0]  LSB_IDX_STATUS       = 8'h15;
  localparam logic [7:0]  LSB_IDX_RSVD_A       = 8'h16;
  localparam logic [7:0]  LSB_IDX_RSVD_B       = 8'h17;
  localparam logic [7:0]  LSB_IDX_LAT_CLEAR    = 8'h18;
  localparam logic [7:0]  LSB_IDX_CONFIG       = 8'h20;
  localparam logic [7:0]  LSB_IDX_IRQ_STATUS   = 8'h21;
  localparam logic [7:0]  LSB_IDX_IRQ_MASK     = 8'h22;
  // reset values
  localparam logic [15:0] LSB_CNT_RESET        = 16'hFFFD;
  localparam logic [15:0] LSB_CNT_CLEARED      = 16'h0000;
  localparam logic [15:0] LSB_STATUS_RESET     = 16'h0000;
  localparam logic [15:0] LSB_RSVD_RESET       = 16'h0000;
  localparam logic [3:0]  LSB_CONFIG_RESET     = 4'h0;
  // status field positions
  localparam int          LSB_BIT_LOS          = 10;
  localparam int          LSB_BIT_FIFO_ERR     = 9;
  localparam int          LSB_BIT_SYNC         = 8;
  localparam int          LSB_BIT_BAD_CODE     = 3;
  // reserved control a: only bits 11:8 and 6:0 are stored
  localparam logic [15:0] LSB_RSVD_A_MASK      = 16'h0F7F;
  // config register: [1:0] lane select, [3:2] pattern select
  localparam int          LSB_CFG_LANE_LSB     = 0;
  localparam int          LSB_CFG_PAT_LSB      = 2;
  // interrupt event bits
  localparam int          LSB_IRQ_LOS          = 0;
  localparam int          LSB_IRQ_FIFO_ERR     = 1;
  localparam int          LSB_IRQ_SYNC_LOST    = 2;
  localparam int          LSB_IRQ_BAD_CODE     = 3;
  localparam int          LSB_IRQ_W            = 4;

  // one lane's raw indications from the receive path
  typedef struct packed {
    logic signal_lost;
    logic sync;
    logic bad_code;
    logic pattern_miss;
  } lsb_lane_s;
endpackage

// >>> verilog/lsb_bank.sv
// apb register bank: low-speed lane error counters and status
//
// What this block does
// - functional mode: lane counter adds one per invalid or disparity-error word.
// - pattern verify mode: lane counter counts mismatches of selected test pattern.
// - reading a lane counter returns its count, then clears it to zero, or to one if an error arrives in the read cycle.
// - lane counters hold 0xFFFD after reset until read or updated.
// - status bit 10 latches high on loss of signal on selected lane.
// - per-lane status bits follow the 2-bit lane select field.
// - status bit 9 latches high when lane alignment fifo reports error.
// - status bit 8 shows sync, latched low on any loss until read.
// - status bit 3 latches high on invalid code on selected lane.
// - status register resets to zero; reserved bits read-only zero.
// - reading latency clear register clears stopwatch status.
// - reserved control b is plain read-write storage resetting zero; a stores only bits 11:8 and 6:0.
`timescale 1ns/10ps
module lsb_bank
  import lsb_pkg::*;
#(
  parameter int NLANE = 3
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              pattern_verify_mode,
  input  wire lsb_lane_s [3:0]   lane_in,
  input  wire logic              lane_align_fifo_fault,
  output logic [1:0]             pattern_select,
  output logic                   latency_stopwatch_clear,
  output logic                   irq
);

  typedef enum logic [1:0] {
    LSB_IDLE   = 2'b00,
    LSB_ANSWER = 2'b01
  } lsb_state_e;

  lsb_state_e           state_q;
  lsb_state_e           state_d;
  logic [15:0]          cnt_q [NLANE];
  logic                 los_q;
  logic                 fifo_q;
  logic                 sync_q;
  logic                 bad_q;
  logic [15:0]          rsvd_a_q;
  logic [15:0]          rsvd_b_q;
  logic [3:0]           cfg_q;
  logic [LSB_IRQ_W-1:0] ist_q;
  logic [LSB_IRQ_W-1:0] imask_q;
  logic                 setup;
  logic                 rd_hit;
  logic                 wr_hit;
  logic [7:0]        idx;
  logic [1:0]        sel;
  lsb_lane_s         cur;
  logic [LSB_IRQ_W-1:0] ev;
  logic [15:0]       status_v;
  logic [15:0]       rdata_v;
  logic              addr_ok;

  function automatic logic hit(input logic [7:0] i, input logic [7:0] r);
    hit = (i == r);
  endfunction

  // one wait state: request taken in setup, answered in the next cycle
  assign setup  = psel && !penable && (state_q == LSB_IDLE);
  assign idx    = paddr[9:2];
  assign rd_hit = setup && !pwrite;
  assign wr_hit = setup && pwrite;
  assign sel    = cfg_q[LSB_CFG_LANE_LSB +: 2];
  assign cur    = lane_in[sel];

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      LSB_IDLE:   state_d = setup ? LSB_ANSWER : LSB_IDLE;
      LSB_ANSWER: state_d = LSB_IDLE;
      default:    state_d = LSB_IDLE;
    endcase
  end

  // answer cycle blocks a second setup from being taken twice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= LSB_IDLE;
    else
      state_q <= state_d;
  end

  // lane counters; lane 0 is counted elsewhere, lanes 1..NLANE here
  genvar g;
  generate
    for (g = 0; g < NLANE; g++)
    begin : g_cnt
      logic        inc;
      logic        clr;
      logic [15:0] cnt_d;
      // mode picks which error source advances the tally
      assign inc = pattern_verify_mode ? lane_in[g+1].pattern_miss
                                       : lane_in[g+1].bad_code;
      assign clr = rd_hit && hit(idx, LSB_IDX_LANE1_CNT + 8'(g));
      always_comb
      begin
        cnt_d = cnt_q[g];
        if (clr)
          // an error in the read cycle is kept, not lost
          cnt_d = inc ? 16'h0001 : LSB_CNT_CLEARED;
        // saturate rather than wrap, so a full tally never looks small
        else if (inc && cnt_q[g] != 16'hFFFF)
          cnt_d = cnt_q[g] + 16'h0001;
      end
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cnt_q[g] <= LSB_CNT_RESET;
        else
          cnt_q[g] <= cnt_d;
      end
    end
  endgenerate

  // latched status; a read returns the held value, then re-arms on live level
  logic st_rd;
  assign st_rd = rd_hit && hit(idx, LSB_IDX_STATUS);

  // loss of signal latches high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      los_q <= 1'b0;
    else if (st_rd)
      los_q <= cur.signal_lost;
    else
      los_q <= los_q | cur.signal_lost;
  end

  // alignment fifo fault latches high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fifo_q <= 1'b0;
    else if (st_rd)
      fifo_q <= lane_align_fifo_fault;
    else
      fifo_q <= fifo_q | lane_align_fifo_fault;
  end

  // sync latches low; zero until the first read re-arms it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_q <= 1'b0;
    else if (st_rd)
      sync_q <= cur.sync;
    else
      sync_q <= sync_q & cur.sync;
  end

  // invalid code latches high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bad_q <= 1'b0;
    else if (st_rd)
      bad_q <= cur.bad_code;
    else
      bad_q <= bad_q | cur.bad_code;
  end

  always_comb
  begin
    status_v = LSB_STATUS_RESET;
    status_v[LSB_BIT_LOS]      = los_q;
    status_v[LSB_BIT_FIFO_ERR] = fifo_q;
    status_v[LSB_BIT_SYNC]     = sync_q;
    status_v[LSB_BIT_BAD_CODE] = bad_q;
  end

  // write decode, one strobe per writable register
  logic wr_rsvd_a;
  logic wr_rsvd_b;
  logic wr_cfg;
  logic wr_mask;
  logic wr_ist;
  assign wr_rsvd_a = wr_hit && hit(idx, LSB_IDX_RSVD_A);
  assign wr_rsvd_b = wr_hit && hit(idx, LSB_IDX_RSVD_B);
  assign wr_cfg    = wr_hit && hit(idx, LSB_IDX_CONFIG) && pstrb[0];
  assign wr_mask   = wr_hit && hit(idx, LSB_IDX_IRQ_MASK) && pstrb[0];
  assign wr_ist    = wr_hit && hit(idx, LSB_IDX_IRQ_STATUS) && pstrb[0];

  // reserved control a: unstored bits read back as zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rsvd_a_q <= LSB_RSVD_RESET;
    else if (wr_rsvd_a)
    begin
      if (pstrb[0])
        rsvd_a_q[7:0] <= pwdata[7:0] & LSB_RSVD_A_MASK[7:0];
      if (pstrb[1])
        rsvd_a_q[15:8] <= pwdata[15:8] & LSB_RSVD_A_MASK[15:8];
    end
  end

  // reserved control b: plain storage, drives nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rsvd_b_q <= LSB_RSVD_RESET;
    else if (wr_rsvd_b)
    begin
      if (pstrb[0])
        rsvd_b_q[7:0] <= pwdata[7:0];
      if (pstrb[1])
        rsvd_b_q[15:8] <= pwdata[15:8];
    end
  end

  // lane and pattern select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= LSB_CONFIG_RESET;
    else if (wr_cfg)
      cfg_q <= pwdata[3:0];
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      imask_q <= '0;
    else if (wr_mask)
      imask_q <= pwdata[LSB_IRQ_W-1:0];
  end

  // interrupt events: live level of each status condition, no edge detect
  assign ev[LSB_IRQ_LOS]       = cur.signal_lost;
  assign ev[LSB_IRQ_FIFO_ERR]  = lane_align_fifo_fault;
  assign ev[LSB_IRQ_SYNC_LOST] = !cur.sync;
  assign ev[LSB_IRQ_BAD_CODE]  = cur.bad_code;

  // one sticky bit per event; a new event wins over a write-one clear
  generate
    for (g = 0; g < LSB_IRQ_W; g++)
    begin : g_ist
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ist_q[g] <= 1'b0;
        else if (ev[g])
          ist_q[g] <= 1'b1;
        else if (wr_ist && pwdata[g])
          ist_q[g] <= 1'b0;
      end
    end
  endgenerate

  // level interrupt, one cycle behind the sticky bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(ist_q & imask_q);
  end

  // read mux
  always_comb
  begin
    rdata_v = 16'h0000;
    addr_ok = 1'b1;
    case (idx)
      LSB_IDX_LANE1_CNT:  rdata_v = cnt_q[0];
      LSB_IDX_LANE2_CNT:  rdata_v = cnt_q[1];
      LSB_IDX_LANE3_CNT:  rdata_v = cnt_q[2];
      LSB_IDX_STATUS:     rdata_v = status_v;
      LSB_IDX_RSVD_A:     rdata_v = rsvd_a_q;
      LSB_IDX_RSVD_B:     rdata_v = rsvd_b_q;
      LSB_IDX_LAT_CLEAR:  rdata_v = 16'h0000;
      LSB_IDX_CONFIG:     rdata_v = {12'h000, cfg_q};
      LSB_IDX_IRQ_STATUS: rdata_v = {12'h000, ist_q};
      LSB_IDX_IRQ_MASK:   rdata_v = {12'h000, imask_q};
      default:            addr_ok = 1'b0;
    endcase
  end

  // answer registered; data captured before the clear-on-read takes effect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_hit)
      prdata <= {16'h0000, rdata_v};
  end

  // fixed single wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  // unmapped index refused, nothing changes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= setup && !addr_ok;
  end

  // one-cycle pulse to the stopwatch; ordering is software's duty
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latency_stopwatch_clear <= 1'b0;
    else
      latency_stopwatch_clear <= rd_hit && hit(idx, LSB_IDX_LAT_CLEAR);
  end

  // pattern choice handed to the checker in the receive path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pattern_select <= 2'b00;
    else
      pattern_select <= cfg_q[LSB_CFG_PAT_LSB +: 2];
  end

endmodule // lsb_bank

// >>> bench/lsb_bank_props.sv
// port checker for the lane status bank
`timescale 1ns/10ps
module lsb_bank_props
#(parameter int NLANE = 3)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  pattern_select,
  input wire logic        latency_stopwatch_clear
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [7:0] idx = paddr[9:2];
  wire mapped = idx inside {[8'h12:8'h18], [8'h20:8'h22]};
  sequence s_setup; psel && !penable; endsequence
  property p_answer; s_setup |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_refuse; s_setup |=> pslverr == !$past(mapped); endproperty
  a_refuse: assert property (p_refuse) else $error("bad error flag");
  property p_upper; pready && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper half set");
  property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_lat;
    psel && !penable && !pwrite && idx == 8'h18 |=> ##[0:1] latency_stopwatch_clear;
  endproperty
  a_lat: assert property (p_lat) else $error("no stopwatch clear");
  property p_lat_one; latency_stopwatch_clear |=> !latency_stopwatch_clear; endproperty
  a_lat_one: assert property (p_lat_one) else $error("clear too long");
  property p_pat;
    psel && !penable && pwrite && idx == 8'h20 |=> ##1 pattern_select == $past(pwdata[3:2], 2);
  endproperty
  a_pat: assert property (p_pat) else $error("pattern select wrong");
endmodule // lsb_bank_props
bind lsb_bank lsb_bank_props #(.NLANE(NLANE)) u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pattern_select,
  .latency_stopwatch_clear);

// >>> bench/tb.sv
// self-checking bench for the lane status bank
`timescale 1ns/10ps
module tb;
  import lsb_pkg::*;
  logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic            pattern_verify_mode = 0, lane_align_fifo_fault = 0, er;
  logic            pready, pslverr, irq, latency_stopwatch_clear;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0, prdata, rd;
  logic [3:0]      pstrb = 4'hF;
  logic [1:0]      pattern_select;
  lsb_lane_s [3:0] lane_in = 16'h4444;
  int              n_fail = 0, compares = 0;
  always #10 pclk = ~pclk;
  lsb_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pattern_verify_mode(pattern_verify_mode),
    .lane_in(lane_in), .lane_align_fifo_fault(lane_align_fifo_fault),
    .pattern_select(pattern_select), .latency_stopwatch_clear(latency_stopwatch_clear),
    .irq(irq));
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    compares++;
    n_fail += int'(got !== exp);
    if (got !== exp) $display("wrong value %s expected %h seen %h", nm, exp, got);
  endtask
  task automatic stop_test(int bad);
    n_fail += bad;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] i, logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, 2'b00, i, 2'b00, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (int k = 0; k < 9 && pready !== 1'b1; k++)
      @(posedge pclk);
    if (pready !== 1'b1)
      stop_test(1);
    {er, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(logic [7:0] i, logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk($sformatf("reg %h", i), rd, e);
  endtask
  // bit 16 is the fifo fault, low half one nibble per lane
  task automatic drive(logic [16:0] v, int n);
    @(posedge pclk);
    {lane_align_fifo_fault, lane_in} <= v;
    repeat (n) @(posedge pclk);
    {lane_align_fifo_fault, lane_in} <= 17'h04444;
  endtask
  task automatic t_reset;
    for (logic [7:0] i = 8'h12; i < 8'h15; i++)
    begin
      rdc(i, 32'hFFFD);
      rdc(i, 32'h0);
    end
    rdc(8'h15, 32'h0);
  endtask
  task automatic t_status;
    apb(1'b1, 8'h20, 32'h1);
    rdc(8'h15, 32'h100);
    drive(17'h0444C, 2);
    rdc(8'h15, 32'h100);
    drive(17'h144A4, 1);
    rdc(8'h15, 32'h608);
    rdc(8'h15, 32'h100);
    rdc(8'h12, 32'h1);
  endtask
  task automatic t_count;
    apb(1'b1, 8'h20, 32'hD);
    pattern_verify_mode <= 1'b1;
    drive(17'h05644, 3);
    rdc(8'h14, 32'h3);
    rdc(8'h13, 32'h0);
  endtask
  task automatic t_regs;
    apb(1'b1, 8'h17, 32'hA5C3);
    rdc(8'h17, 32'hA5C3);
    apb(1'b1, 8'h15, 32'hFFFF);
    rdc(8'h15, 32'h100);
    rdc(8'h18, 32'h0);
    rdc(8'h30, 32'h0);
    chk("pslverr", 32'(er), 32'h1);
    rdc(8'h21, 32'hF);
    apb(1'b1, 8'h22, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", 32'(irq), 32'h1);
    apb(1'b1, 8'h21, 32'hF);
    repeat (2) @(posedge pclk);
    chk("irq", 32'(irq), 32'h0);
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_status();
    t_count();
    t_regs();
    stop_test(0);
  end
endmodule // tb
